// ---- rtl/pdac_defines.svh ----
`ifndef PDAC_DEFINES_SVH
`define PDAC_DEFINES_SVH

// Register select locations
`define PDAC_RS_ADDR_WR    2'h0
`define PDAC_RS_COLOUR     2'h1
`define PDAC_RS_MAGIC      2'h2
`define PDAC_RS_ADDR_RD    2'h3

// Pixel command register
`define PDAC_CMD_RESET     8'h00
`define PDAC_CMD_FMT_HI    7
`define PDAC_CMD_FMT_LO    5
`define PDAC_CMD_EXT_REG   4
`define PDAC_CMD_EXT_PIX   3
`define PDAC_CMD_SLEEP     0
`define PDAC_FMT_15        3'h5
`define PDAC_FMT_16        3'h6
`define PDAC_FMT_24        3'h7

// Other reset values
`define PDAC_MASK_RESET    8'hff
`define PDAC_BYTE_RESET    8'h00
`define PDAC_IDX_RESET     16'h0000

// Extended register indexes
`define PDAC_IDX_COMPANY   16'h0000
`define PDAC_IDX_DEVICE    16'h0001
`define PDAC_IDX_PRIMARY   16'h0003
`define PDAC_IDX_SECONDARY 16'h0004

// Identity values are arbitrary
`define PDAC_COMPANY_ID    8'h5a
`define PDAC_DEVICE_ID     8'h3c

// Comparator trip point, half of full scale
`define PDAC_SENSE_THRESH  8'h80

`endif

// ---- rtl/pdac_pkg.sv ----
package pdac_pkg;

  typedef struct packed {
    logic       rd_n;
    logic       wr_n;
    logic [1:0] rs;
    logic [7:0] data;
  } pdac_pins_s;

  typedef enum logic [2:0] {
    MG_MASK1, MG_MASK2, MG_MASK3, MG_MASK4, MG_CMD, MG_IDX_LO, MG_IDX_HI, MG_INDEXED
  } pdac_magic_e;

  typedef enum logic [1:0] {
    PM_INDEXED8, PM_SERIAL8, PM_DIRECT15, PM_DIRECT16
  } pdac_mode_e;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] prim;
    logic [7:0] sec;
  } pdac_cfg_s;

  typedef struct packed {
    logic [15:0] word;
    logic        blank_n;
    logic        mix;
  } pdac_raw_s;

  typedef struct packed {
    logic       blank_n;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pdac_colour_s;

  typedef struct packed {
    pdac_pins_s  ff1;
    pdac_pins_s  ff2;
    logic        rd_prev;
    logic        wr_prev;
    logic [1:0]  rs_lat;
    pdac_magic_e magic;
    logic [7:0]  mask;
    logic [7:0]  cmd;
    logic [15:0] idx;
    logic [7:0]  prim;
    logic [7:0]  sec;
    logic [7:0]  addr;
    logic [7:0]  dout;
    logic        oe_n;
    logic        cfg_tgl;
  } pdac_host_s;

  typedef struct packed {
    logic [2:0]         tgl_s;
    pdac_cfg_s          cfg;
    logic               a_valid;
    pdac_raw_s          a;
    logic               half;
    pdac_colour_s [1:0] buf_e;
    logic               wp;
    logic               rp;
    logic [1:0]         cnt;
    logic               sense_n;
  } pdac_pix_s;

endpackage : pdac_pkg

// ---- rtl/pdac_top.sv ----
// Function
// - Register select is latched on the falling edge of the active strobe.
// - Write data is stored on the rising edge of the write strobe.
// - Read drives selected register, bus released after read strobe rises.
// - Pixel word, blank and mix are sampled together on a pixel clock rise when pixel_valid and pixel_in_ready are high.
// - Each pixel word is interpreted per the current pixel mode.
// - With extended modes, mix low picks primary, high picks secondary.
// - Mix selection can change interpretation on every pixel word; both serialized pixels of a word share its mix.
// - Blank low turns colour off after the same pipeline delay.
// - Serializing mode splits a 16-bit word into two 8-bit pixels.
// - Sense output low when any colour channel reaches or exceeds half scale.
// - Reads of location 2 advance state; fifth read gives command.
// - Access to any other location returns the state to the first.
// - If command bit 4 is set, then index low, index high, then indexed access with auto-increment.
`timescale 1ns/1ps
`include "pdac_defines.svh"

module pdac_top
  import pdac_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         host_read_strobe_n,
  input  wire logic         host_write_strobe_n,
  input  wire logic [1:0]   reg_select,
  input  wire logic [7:0]   host_data_in,
  output logic      [7:0]   host_data_out,
  output logic              host_data_oe_n,
  input  wire logic         pclk,
  input  wire logic [15:0]  pixel_word,
  input  wire logic         blank_n,
  input  wire logic         pixel_mode_mix_sel,
  input  wire logic         pixel_valid,
  output logic              pixel_in_ready,
  output logic              pix_out_valid,
  input  wire logic         pix_out_ready,
  output pdac_colour_s      pix_out,
  output logic              output_level_sense_n
);

  pdac_host_s h_q;
  pdac_host_s h_d;
  pdac_pix_s  p_q;
  pdac_pix_s  p_d;

  // Host side register read selection
  function automatic logic [7:0] host_read_value(input logic [1:0]  rs,
                                                 input pdac_magic_e mg,
                                                 input logic [7:0]  mask,
                                                 input logic [7:0]  cmd,
                                                 input logic [15:0] idx,
                                                 input logic [7:0]  prim,
                                                 input logic [7:0]  sec,
                                                 input logic [7:0]  addr);
    logic [7:0] v;
    v = `PDAC_BYTE_RESET;
    case (rs)
      `PDAC_RS_ADDR_WR, `PDAC_RS_ADDR_RD: v = addr;
      `PDAC_RS_MAGIC: begin
        case (mg)
          MG_CMD:    v = cmd;
          MG_IDX_LO: v = idx[7:0];
          MG_IDX_HI: v = idx[15:8];
          MG_INDEXED: begin
            case (idx)
              `PDAC_IDX_COMPANY:   v = `PDAC_COMPANY_ID;
              `PDAC_IDX_DEVICE:    v = `PDAC_DEVICE_ID;
              `PDAC_IDX_PRIMARY:   v = prim;
              `PDAC_IDX_SECONDARY: v = sec;
              default:             v = `PDAC_BYTE_RESET;
            endcase
          end
          default:   v = mask;
        endcase
      end
      default: v = `PDAC_BYTE_RESET;
    endcase
    return v;
  endfunction : host_read_value

  // Host port, clk domain
  always_comb begin
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;
    rd_fall = 1'b0;
    rd_rise = 1'b0;
    wr_fall = 1'b0;
    wr_rise = 1'b0;
    h_d = h_q;
    h_d.ff1 = '{rd_n: host_read_strobe_n, wr_n: host_write_strobe_n,
                rs: reg_select, data: host_data_in};
    h_d.ff2 = h_q.ff1;
    h_d.rd_prev = h_q.ff2.rd_n;
    h_d.wr_prev = h_q.ff2.wr_n;
    rd_fall = h_q.rd_prev && !h_q.ff2.rd_n;
    rd_rise = !h_q.rd_prev && h_q.ff2.rd_n;
    wr_fall = h_q.wr_prev && !h_q.ff2.wr_n;
    wr_rise = !h_q.wr_prev && h_q.ff2.wr_n;
    // either falling strobe latches register select, with no priority between them
    if (rd_fall || wr_fall) begin
      h_d.rs_lat = h_q.ff2.rs;
    end
    if (rd_fall) begin
      h_d.dout = host_read_value(h_q.ff2.rs, h_q.magic, h_q.mask, h_q.cmd, h_q.idx,
                                 h_q.prim, h_q.sec, h_q.addr);
      h_d.oe_n = 1'b0;
    end
    if (h_q.ff2.rd_n) begin
      h_d.oe_n = 1'b1;
    end
    // read of location 2 advances state
    if (rd_rise) begin
      if (h_q.rs_lat != `PDAC_RS_MAGIC) begin
        h_d.magic = MG_MASK1;
      end else begin
        case (h_q.magic)
          MG_MASK1:   h_d.magic = MG_MASK2;
          MG_MASK2:   h_d.magic = MG_MASK3;
          MG_MASK3:   h_d.magic = MG_MASK4;
          MG_MASK4:   h_d.magic = MG_CMD;
          MG_CMD:     h_d.magic = h_q.cmd[`PDAC_CMD_EXT_REG] ? MG_IDX_LO : MG_MASK1;
          MG_IDX_LO:  h_d.magic = MG_IDX_HI;
          MG_IDX_HI:  h_d.magic = MG_INDEXED;
          MG_INDEXED: h_d.idx = h_q.idx + 16'h0001;
          default:    h_d.magic = MG_MASK1;
        endcase
      end
    end
    if (wr_rise) begin
      // Any write asks the pixel side to recapture
      h_d.cfg_tgl = !h_q.cfg_tgl;
      case (h_q.rs_lat)
        `PDAC_RS_ADDR_WR, `PDAC_RS_ADDR_RD: h_d.addr = h_q.ff2.data;
        `PDAC_RS_MAGIC: begin
          case (h_q.magic)
            MG_CMD: begin
              h_d.cmd = h_q.ff2.data;
              h_d.magic = MG_MASK1;
            end
            MG_IDX_LO: begin
              h_d.idx[7:0] = h_q.ff2.data;
              h_d.magic = MG_IDX_HI;
            end
            MG_IDX_HI: begin
              h_d.idx[15:8] = h_q.ff2.data;
              h_d.magic = MG_INDEXED;
            end
            MG_INDEXED: begin
              if (h_q.idx == `PDAC_IDX_PRIMARY) begin
                h_d.prim = h_q.ff2.data;
              end
              if (h_q.idx == `PDAC_IDX_SECONDARY) begin
                h_d.sec = h_q.ff2.data;
              end
              h_d.idx = h_q.idx + 16'h0001;
            end
            default: begin
              h_d.mask = h_q.ff2.data;
              h_d.magic = MG_MASK1;
            end
          endcase
        end
        default: h_d.magic = MG_MASK1;
      endcase
      if (h_q.rs_lat != `PDAC_RS_MAGIC) begin
        h_d.magic = MG_MASK1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      h_q <= '{ff1: '{rd_n: 1'b1, wr_n: 1'b1, rs: 2'h0, data: 8'h00},
               ff2: '{rd_n: 1'b1, wr_n: 1'b1, rs: 2'h0, data: 8'h00},
               rd_prev: 1'b1, wr_prev: 1'b1, rs_lat: 2'h0, magic: MG_MASK1,
               mask: `PDAC_MASK_RESET, cmd: `PDAC_CMD_RESET, idx: `PDAC_IDX_RESET,
               prim: `PDAC_BYTE_RESET, sec: `PDAC_BYTE_RESET, addr: `PDAC_BYTE_RESET,
               dout: `PDAC_BYTE_RESET, oe_n: 1'b1, cfg_tgl: 1'b0};
    end else begin
      h_q <= h_d;
    end
  end

  assign host_data_out  = h_q.dout;
  assign host_data_oe_n = h_q.oe_n;

  // Pixel mode for one word; mix travels with its own word
  function automatic pdac_mode_e pick_mode(input pdac_cfg_s c, input logic mix);
    pdac_mode_e m;
    m = PM_INDEXED8;
    if (c.cmd[`PDAC_CMD_EXT_PIX]) begin
      m = pdac_mode_e'(mix ? c.sec[1:0] : c.prim[1:0]);
    end else begin
      case (c.cmd[`PDAC_CMD_FMT_HI:`PDAC_CMD_FMT_LO])
        `PDAC_FMT_15:             m = PM_DIRECT15;
        `PDAC_FMT_16, `PDAC_FMT_24: m = PM_DIRECT16;
        default:                  m = PM_INDEXED8;
      endcase
    end
    return m;
  endfunction : pick_mode

  function automatic pdac_colour_s colourise(input pdac_mode_e m, input pdac_raw_s a,
                                             input logic half, input logic off);
    pdac_colour_s c;
    logic [7:0]   b;
    b = half ? a.word[15:8] : a.word[7:0];
    c = '{blank_n: a.blank_n, red: b, green: b, blue: b};
    case (m)
      PM_DIRECT15: c = '{blank_n: a.blank_n, red: {a.word[14:10], a.word[14:12]},
                         green: {a.word[9:5], a.word[9:7]},
                         blue: {a.word[4:0], a.word[4:2]}};
      PM_DIRECT16: c = '{blank_n: a.blank_n, red: {a.word[15:11], a.word[15:13]},
                         green: {a.word[10:5], a.word[10:9]},
                         blue: {a.word[4:0], a.word[4:2]}};
      default: c = c;
    endcase
    if (!a.blank_n || off) begin
      c.red = 8'h00;
      c.green = 8'h00;
      c.blue = 8'h00;
    end
    return c;
  endfunction : colourise

  // Pixel path, pclk domain
  always_comb begin
    pdac_mode_e   mode;
    pdac_colour_s col;
    logic         push;
    logic         pop;
    logic         last;
    logic         take;
    mode = PM_INDEXED8;
    col = '0;
    push = 1'b0;
    pop = 1'b0;
    last = 1'b0;
    take = 1'b0;
    p_d = p_q;
    // Toggle handshake; config is stable once the toggle is seen
    // Writes closer than a pixel clock apart may go unseen until a later write
    p_d.tgl_s = {p_q.tgl_s[1:0], h_q.cfg_tgl};
    if (p_q.tgl_s[2] != p_q.tgl_s[1]) begin
      p_d.cfg = '{cmd: h_q.cmd, prim: h_q.prim, sec: h_q.sec};
    end
    mode = pick_mode(p_q.cfg, p_q.a.mix);
    last = (mode != PM_SERIAL8) || p_q.half;
    col = colourise(mode, p_q.a, p_q.half, p_q.cfg.cmd[`PDAC_CMD_SLEEP]);
    push = p_q.a_valid && (p_q.cnt != 2'h2);
    pop = (p_q.cnt != 2'h0) && pix_out_ready;
    pixel_in_ready = !p_q.a_valid || (push && last);
    take = pixel_valid && pixel_in_ready;
    // fixed stage, word and flags move together
    if (push) begin
      p_d.buf_e[p_q.wp] = col;
      p_d.wp = !p_q.wp;
      p_d.half = !last;
      if (last) begin
        p_d.a_valid = 1'b0;
      end
    end
    // sample word, blank and mix together
    if (take) begin
      p_d.a = '{word: pixel_word, blank_n: blank_n, mix: pixel_mode_mix_sel};
      p_d.a_valid = 1'b1;
    end
    if (pop) begin
      p_d.rp = !p_q.rp;
      p_d.sense_n = !((p_q.buf_e[p_q.rp].red >= `PDAC_SENSE_THRESH) ||
                      (p_q.buf_e[p_q.rp].green >= `PDAC_SENSE_THRESH) ||
                      (p_q.buf_e[p_q.rp].blue >= `PDAC_SENSE_THRESH));
    end
    p_d.cnt = p_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge pclk or negedge resetn) begin
    if (!resetn) begin
      p_q <= '{tgl_s: 3'b000,
               cfg: '{cmd: `PDAC_CMD_RESET, prim: 8'h00, sec: 8'h00},
               a_valid: 1'b0, a: '0, half: 1'b0, buf_e: '0, wp: 1'b0, rp: 1'b0,
               cnt: 2'h0, sense_n: 1'b1};
    end else begin
      p_q <= p_d;
    end
  end

  assign pix_out_valid        = (p_q.cnt != 2'h0);
  assign pix_out              = p_q.buf_e[p_q.rp];
  assign output_level_sense_n = p_q.sense_n;

endmodule : pdac_top

// ---- tb/pdac_monitor.sv ----
`timescale 1ns/1ps
module pdac_monitor
  import pdac_pkg::*;
(
  input wire logic         clk,
  input wire logic         resetn,
  input wire logic         host_read_strobe_n,
  input wire logic         host_write_strobe_n,
  input wire logic         host_data_oe_n,
  input wire logic         pclk,
  input wire logic         pixel_valid,
  input wire logic         pixel_in_ready,
  input wire logic         pix_out_valid,
  input wire logic         pix_out_ready,
  input wire pdac_colour_s pix_out,
  input wire logic         output_level_sense_n
);
  logic hot;
  // Any channel at or above half scale
  assign hot = pix_out.red[7] | pix_out.green[7] | pix_out.blue[7];

  property p_rd_on;
    @(posedge clk) disable iff (!resetn)
    $fell(host_read_strobe_n) |-> ##[3:4] !host_data_oe_n;
  endproperty
  a_rd_on: assert property (p_rd_on) else $error("bus not driven on read");
  property p_rd_off;
    @(posedge clk) disable iff (!resetn)
    $rose(host_read_strobe_n) |-> ##[3:4] host_data_oe_n;
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("bus not released");
  property p_idle;
    @(posedge clk) disable iff (!resetn) host_read_strobe_n [*6] |-> host_data_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("bus driven while idle");
  property p_wr_quiet;
    @(posedge clk) disable iff (!resetn)
    $fell(host_write_strobe_n) |-> ##4 host_data_oe_n;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("bus driven on write");
  property p_hold;
    @(posedge pclk) disable iff (!resetn)
    pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled pixel changed");
  property p_blank;
    @(posedge pclk) disable iff (!resetn)
    pix_out_valid && !pix_out.blank_n |-> pix_out[23:0] == '0;
  endproperty
  a_blank: assert property (p_blank) else $error("blanked pixel has colour");
  property p_sense;
    @(posedge pclk) disable iff (!resetn)
    pix_out_valid && pix_out_ready |=> output_level_sense_n != $past(hot);
  endproperty
  a_sense: assert property (p_sense) else $error("sense level wrong");
  property p_take;
    @(posedge pclk) disable iff (!resetn)
    pixel_valid && pixel_in_ready && !pix_out_valid |-> ##2 pix_out_valid;
  endproperty
  a_take: assert property (p_take) else $error("taken pixel not shown");
  c_read: cover property (@(posedge clk) $fell(host_data_oe_n));
  c_full: cover property (@(posedge pclk) pix_out_valid && !pixel_in_ready);
  c_blank: cover property (@(posedge pclk) pix_out_valid && !pix_out.blank_n);
endmodule : pdac_monitor

bind pdac_top pdac_monitor i_pdac_monitor (
  .clk, .resetn, .host_read_strobe_n, .host_write_strobe_n, .host_data_oe_n, .pclk,
  .pixel_valid, .pixel_in_ready, .pix_out_valid, .pix_out_ready, .pix_out,
  .output_level_sense_n
);

// ---- tb/pdac_pix_src.sv ----
`timescale 1ns/1ps
module pdac_pix_src (
  input  wire logic  pclk,
  input  wire logic  pixel_in_ready,
  output logic [15:0] pixel_word,
  output logic       blank_n,
  output logic       pixel_mode_mix_sel,
  output logic       pixel_valid
);
  initial begin
    pixel_word = 16'h0000;
    blank_n = 1'b1;
    pixel_mode_mix_sel = 1'b0;
    pixel_valid = 1'b0;
  end
  task automatic send(input logic [15:0] w, input logic b, input logic m, output logic ok);
    int n;
    n = 0;
    @(negedge pclk);
    pixel_word = w;
    blank_n = b;
    pixel_mode_mix_sel = m;
    pixel_valid = 1'b1;
    #1;
    while (!pixel_in_ready && n < 50) begin
      @(negedge pclk);
      n++;
    end
    ok = (n < 50);
    @(negedge pclk);
    pixel_valid = 1'b0;
    // Released lines toggle, not stale
    pixel_word = ~w;
    blank_n = ~b;
    pixel_mode_mix_sel = ~m;
  endtask : send
endmodule : pdac_pix_src

// ---- tb/pdac_top_test.sv ----
`timescale 1ns/1ps
`include "pdac_defines.svh"
module pdac_top_test
  import pdac_pkg::*;
;
  logic         clk = 0, pclk = 0, resetn = 0, drv_en = 0, ok;
  logic         host_read_strobe_n = 1, host_write_strobe_n = 1, pix_out_ready = 0;
  logic [1:0]   reg_select = 0;
  logic [7:0]   drv_d = 0, host_data_in, host_data_out, q;
  logic         host_data_oe_n, pixel_in_ready, pix_out_valid, output_level_sense_n;
  logic         blank_n, pixel_mode_mix_sel, pixel_valid;
  logic [15:0]  pixel_word;
  pdac_colour_s pix_out;
  int           err_count = 0, checked = 0;

  always #5 clk = ~clk;
  // Offset keeps edges apart from clk
  always begin
    #3;
    forever #40 pclk = ~pclk;
  end
  // Bus level from whoever drives
  assign host_data_in = !host_data_oe_n ? host_data_out : (drv_en ? drv_d : ~host_data_out);

  pdac_top i_pdac_top (.clk, .resetn, .host_read_strobe_n, .host_write_strobe_n,
    .reg_select, .host_data_in, .host_data_out, .host_data_oe_n, .pclk, .pixel_word,
    .blank_n, .pixel_mode_mix_sel, .pixel_valid, .pixel_in_ready, .pix_out_valid,
    .pix_out_ready, .pix_out, .output_level_sense_n);
  pdac_pix_src i_pdac_pix_src (.pclk, .pixel_in_ready, .pixel_word, .blank_n,
    .pixel_mode_mix_sel, .pixel_valid);

  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input logic fail);
    if (fail) begin
      err_count++;
      give_verdict();
    end
  endtask : tmo
  task automatic acc(input logic wr, input logic [1:0] rs, input logic [7:0] d);
    @(negedge clk);
    reg_select = rs;
    drv_d = d;
    drv_en = wr;
    if (wr) host_write_strobe_n = 1'b0;
    else host_read_strobe_n = 1'b0;
    repeat (6) @(negedge clk);
    q = host_data_out;
    host_read_strobe_n = 1'b1;
    host_write_strobe_n = 1'b1;
    repeat (6) @(negedge clk);
    drv_en = 1'b0;
  endtask : acc
  task automatic rd(input logic [1:0] rs, input logic [7:0] e);
    acc(1'b0, rs, 8'h00);
    chk(25'(q), 25'(e));
  endtask : rd
  task automatic unlock(input logic [7:0] m, input logic [7:0] c);
    repeat (4) rd(2'h2, m);
    rd(2'h2, c);
  endtask : unlock
  task automatic pop(input logic [24:0] e);
    int n;
    n = 0;
    @(negedge pclk);
    while (!pix_out_valid && n < 50) begin
      @(negedge pclk);
      n++;
    end
    tmo(n == 50);
    chk(pix_out, e);
    pix_out_ready = 1'b1;
    @(negedge pclk);
    pix_out_ready = 1'b0;
  endtask : pop

  task automatic t_regs;
    rd(2'h2, `PDAC_MASK_RESET);
    acc(1'b1, 2'h2, 8'h96);
    rd(2'h2, 8'h96);
    rd(2'h2, 8'h96);
    rd(2'h0, 8'h00);
    unlock(8'h96, `PDAC_CMD_RESET);
    repeat (4) rd(2'h2, 8'h96);
    acc(1'b1, 2'h2, 8'h18);
    unlock(8'h96, 8'h18);
    acc(1'b1, 2'h2, 8'h03);
    acc(1'b1, 2'h2, 8'h00);
    acc(1'b1, 2'h2, 8'h01);
    acc(1'b1, 2'h2, 8'h00);
    rd(2'h1, 8'h00);
    unlock(8'h96, 8'h18);
    acc(1'b1, 2'h2, 8'h00);
    acc(1'b1, 2'h2, 8'h00);
    rd(2'h2, `PDAC_COMPANY_ID);
    rd(2'h2, `PDAC_DEVICE_ID);
    rd(2'h2, 8'h00);
    rd(2'h2, 8'h01);
    rd(2'h2, 8'h00);
  endtask : t_regs

  task automatic t_pixels;
    // Config crosses slowly, let it settle
    repeat (4) @(negedge pclk);
    i_pdac_pix_src.send(16'h9a3c, 1'b1, 1'b0, ok);
    tmo(!ok);
    i_pdac_pix_src.send(16'h0081, 1'b1, 1'b1, ok);
    tmo(!ok);
    repeat (3) @(negedge pclk);
    chk(25'(pixel_in_ready), 25'h0);
    pop({1'b1, {3{8'h3c}}});
    pop({1'b1, {3{8'h9a}}});
    @(negedge pclk);
    chk(25'(output_level_sense_n), 25'h0);
    pop({1'b1, {3{8'h81}}});
    i_pdac_pix_src.send(16'h00ff, 1'b0, 1'b1, ok);
    tmo(!ok);
    pop(25'h0);
    @(negedge pclk);
    chk(25'(output_level_sense_n), 25'h1);
  endtask : t_pixels

  task automatic t_modes;
    rd(2'h1, 8'h00);
    unlock(8'h96, 8'h18);
    acc(1'b1, 2'h2, 8'h03);
    acc(1'b1, 2'h2, 8'h00);
    acc(1'b1, 2'h2, 8'h02);
    acc(1'b1, 2'h2, 8'h03);
    repeat (4) @(negedge pclk);
    i_pdac_pix_src.send(16'h4210, 1'b1, 1'b0, ok);
    tmo(!ok);
    pop({1'b1, 24'h84_8484});
    chk(25'(output_level_sense_n), 25'h0);
    i_pdac_pix_src.send(16'h4210, 1'b1, 1'b1, ok);
    tmo(!ok);
    pop({1'b1, 24'h42_4184});
    rd(2'h1, 8'h00);
    repeat (4) rd(2'h2, 8'h96);
    acc(1'b1, 2'h2, 8'h19);
    repeat (4) @(negedge pclk);
    i_pdac_pix_src.send(16'h4210, 1'b1, 1'b0, ok);
    tmo(!ok);
    pop({1'b1, 24'h00_0000});
    chk(25'(output_level_sense_n), 25'h1);
  endtask : t_modes

  initial begin
    repeat (8) @(negedge pclk);
    resetn = 1'b1;
    t_regs();
    t_pixels();
    t_modes();
    give_verdict();
  end
endmodule : pdac_top_test
